// ==== adcc_defs.vh ====
/*
  Constants for the converter control block: register offsets, reset values,
  field positions and timing counts. Included by the design files and by the bench.
*/
`ifndef ADCC_DEFS_VH
`define ADCC_DEFS_VH

// ----------------------------------------
// Register byte offsets (APB, word aligned)
// ----------------------------------------
`define ADCC_OFF_MODE    12'h000
`define ADCC_OFF_START   12'h004
`define ADCC_OFF_RES_HI  12'h008
`define ADCC_OFF_RES_LO  12'h00c
`define ADCC_OFF_STBY    12'h010
`define ADCC_OFF_PORT_MODE_REG1    12'h014
`define ADCC_OFF_EDGE    12'h018
`define ADCC_OFF_IRQ     12'h01c
`define ADCC_OFF_IEN     12'h020

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCC_MODE_RST    8'h30
`define ADCC_START_RST   8'h7f
`define ADCC_STBY_RST    8'hff

// ----------------------------------------
// Field positions
// ----------------------------------------
`define ADCC_MODE_SPEED  7
`define ADCC_MODE_EXT_TRIGGER_ENABLE   6
`define ADCC_START_FLAG  7
`define ADCC_STBY_ADC    4
`define ADCC_PORT_MODE_REG1_TRIG   4
`define ADCC_EDGE_TRIG   4
`define ADCC_IRQ_DONE    0

// ----------------------------------------
// Timing and encodings
// ----------------------------------------
`define ADCC_SLOW_CYCLES 8'd62
`define ADCC_FAST_CYCLES 8'd31
`define ADCC_SLOW_BIT_CLKS 3'd6
`define ADCC_FAST_BIT_CLKS 3'd3
`define ADCC_RES_BITS    10
`define ADCC_CH_AN1      4'h5

`endif

// ==== adcc_sar.v ====
/*
  Successive approximation engine: one result bit per step over a conversion
  period of 62 or 31 clocks, six or three clocks per bit. Assumes the trial
  code reaches the comparator through one register and is answered a clock later.
*/
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_sar #(
  parameter BITS = `ADCC_RES_BITS
) (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire start,
  input wire abort,
  input wire fast,
  // Analog comparator
  input wire cmp_hi,
  output wire [BITS-1:0] dac_code,
  // Result
  output reg done,
  output reg [BITS-1:0] result
);

  localparam [7:0] SLOW = `ADCC_SLOW_CYCLES;
  localparam [7:0] FAST = `ADCC_FAST_CYCLES;
  localparam [2:0] SLOW_BIT = `ADCC_SLOW_BIT_CLKS;
  localparam [2:0] FAST_BIT = `ADCC_FAST_BIT_CLKS;

  reg busy_q;
  reg [7:0] cnt_q;
  reg [2:0] sub_q;
  reg [BITS-1:0] trial_q;
  reg [BITS-1:0] bit_q;
  wire [7:0] period = fast ? FAST : SLOW;
  wire [2:0] sub_last = (fast ? FAST_BIT : SLOW_BIT) - 3'd1;
  // Each step waits for the registered trial code to be compared
  wire step = (sub_q == sub_last) && (bit_q != {BITS{1'b0}});

  assign dac_code = trial_q | bit_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      cnt_q <= 8'h00;
      sub_q <= 3'd0;
      trial_q <= {BITS{1'b0}};
      bit_q <= {BITS{1'b0}};
      done <= 1'b0;
      result <= {BITS{1'b0}};
    end else begin
      done <= 1'b0;
      if (abort) begin
        busy_q <= 1'b0;
      end else if (start && !busy_q) begin
        busy_q <= 1'b1;
        cnt_q <= 8'h00;
        sub_q <= 3'd0;
        trial_q <= {BITS{1'b0}};
        bit_q <= {1'b1, {(BITS-1){1'b0}}};
      end else if (busy_q) begin
        cnt_q <= cnt_q + 8'h01;
        sub_q <= (sub_q == sub_last) ? 3'd0 : sub_q + 3'd1;
        if (step) begin
          if (cmp_hi) trial_q <= trial_q | bit_q; // R2
          bit_q <= bit_q >> 1;
        end
        if (cnt_q == period - 8'h01) begin
          busy_q <= 1'b0;
          done <= 1'b1;
          result <= trial_q; // R2
        end
      end
    end
  end

endmodule // adcc_sar

`default_nettype wire

// ==== adcc_ctrl.v ====
/*
  Converter control block: APB registers, start flag, external trigger,
  result capture, done interrupt, module standby and low-power hold.
  Assumes one clock, pclk, and an analog core behind the comparator input.
*/
// Chosen here: the address map and the APB slave port.
// Contract
// R1 - Standby release bit: 0 puts converter in standby, 1 releases; resets to 1
// R2 - Conversion by successive approximation, result is 10 bits
// R3 - Writing 1 to start flag starts; flag reads 1 until hardware clears it
// R4 - Start flag falling on completion sets the done request bit
// R5 - Done interrupt reaches the processor only while its enable bit is 1
// R6 - Software clears the start flag before changing speed or channel
// R7 - Trigger pin starts only when function select and trigger enable are 1
// R8 - Selected edge on trigger pin sets start flag and starts conversion
// R9 - Reset sets mode and start registers; result registers keep contents
// R10 - Runs in active and sleep; all registers held in low-power modes (APB writes still update the control registers)
// R11 - Result loaded in same cycle flag clears, then converter idles
// R12 - Software reads results only while start flag reads 0
// R13 - Software waits 10 clocks after standby release before starting
// R14 - Channel code 0101 routes analog input 1 to the converter
// R15 - Writing 0 to the start flag stops a running conversion
// R16 - Speed bit selects 62 clocks when 0, 31 clocks when 1
// R17 - Upper 8 result bits in high register, lower 2 at top of low
// R18 - Clocked by pclk; trigger pin synchronised before edge detection
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"

module adcc_ctrl #(
  parameter BITS = `ADCC_RES_BITS
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Power state: high in watch, subactive, subsleep or standby
  input wire low_power,
  // External trigger pin
  input wire ext_trigger_pin,
  // Analog side
  input wire cmp_hi,
  output reg [BITS-1:0] dac_code_q,
  output reg [3:0] channel_select_q,
  output reg analog_input_1_sel_q,
  output reg converter_enable_q,
  // Interrupt
  output reg irq_q
);

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam [7:0] MODE_RST = `ADCC_MODE_RST;
  reg conversion_speed_select_q;
  reg ext_trigger_enable_q;
  reg conversion_start_flag_q;
  reg converter_standby_release_q;
  reg trigger_pin_function_select_q;
  reg trigger_edge_select_q;
  reg conversion_done_request_q;
  reg conversion_done_irq_enable_q;
  reg [BITS-1:0] result_q;
  reg [2:0] trig_sync_q;
  reg trig_last_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  wire access = psel && penable;
  wire wr = access && pwrite && pstrb[0];
  wire rd = access && !pwrite;
  wire mapped = (paddr[1:0] == 2'b00) && (paddr <= `ADCC_OFF_IEN);
  wire wr_mode = wr && (paddr == `ADCC_OFF_MODE);
  wire wr_start = wr && (paddr == `ADCC_OFF_START);
  wire wr_stby = wr && (paddr == `ADCC_OFF_STBY);
  wire wr_port_mode_reg1 = wr && (paddr == `ADCC_OFF_PORT_MODE_REG1);
  wire wr_edge = wr && (paddr == `ADCC_OFF_EDGE);
  wire wr_irq = wr && (paddr == `ADCC_OFF_IRQ);
  wire wr_ien = wr && (paddr == `ADCC_OFF_IEN);
  wire rd_irq = rd && (paddr == `ADCC_OFF_IRQ);

  // Held in low-power and module standby: only the bus and the trigger synchroniser move
  wire run = !low_power && converter_standby_release_q; // R10

  // ----------------------------------------
  // Trigger synchroniser and edge detect
  // ----------------------------------------
  wire trig_level_ok = (trig_sync_q[2] == trig_sync_q[1]);
  wire trig_level = trig_sync_q[2];
  wire trig_edge = trig_level_ok && (trig_level != trig_last_q) &&
                   (trig_level == trigger_edge_select_q);
  wire trig_start = run && trigger_pin_function_select_q && ext_trigger_enable_q &&
                    trig_edge; // R7

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trig_sync_q <= 3'b000;
      trig_last_q <= 1'b0;
    end else begin
      trig_sync_q <= {trig_sync_q[1:0], ext_trigger_pin}; // R18
      if (trig_level_ok) trig_last_q <= trig_level;
    end
  end

  // ----------------------------------------
  // Conversion engine
  // ----------------------------------------
  wire sw_start = wr_start && pwdata[`ADCC_START_FLAG];
  wire sw_stop = wr_start && !pwdata[`ADCC_START_FLAG];
  wire go = run && !conversion_start_flag_q && (sw_start || trig_start);
  wire sar_done;
  wire [BITS-1:0] sar_result;
  wire [BITS-1:0] sar_code;
  wire sar_abort = sw_stop || !run; // R15

  adcc_sar #(.BITS(BITS)) u_sar (
    .pclk(pclk),
    .presetn(presetn),
    .start(go),
    .abort(sar_abort),
    .fast(conversion_speed_select_q), // R16
    .cmp_hi(cmp_hi),
    .dac_code(sar_code),
    .done(sar_done),
    .result(sar_result)
  );

  wire finish = sar_done && conversion_start_flag_q && run;

  // ----------------------------------------
  // Control state
  // ----------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_speed_select_q <= MODE_RST[`ADCC_MODE_SPEED]; // R9
      ext_trigger_enable_q <= 1'b0;
      channel_select_q <= 4'h0;
      conversion_start_flag_q <= 1'b0;
      converter_standby_release_q <= 1'b1; // R1
      trigger_pin_function_select_q <= 1'b0;
      trigger_edge_select_q <= 1'b0;
      conversion_done_irq_enable_q <= 1'b0;
    end else begin
      if (wr_mode) begin
        conversion_speed_select_q <= pwdata[`ADCC_MODE_SPEED];
        ext_trigger_enable_q <= pwdata[`ADCC_MODE_EXT_TRIGGER_ENABLE];
        channel_select_q <= pwdata[3:0];
      end
      if (wr_stby) converter_standby_release_q <= pwdata[`ADCC_STBY_ADC]; // R1
      if (wr_port_mode_reg1) trigger_pin_function_select_q <= pwdata[`ADCC_PORT_MODE_REG1_TRIG];
      if (wr_edge) trigger_edge_select_q <= pwdata[`ADCC_EDGE_TRIG];
      if (wr_ien) conversion_done_irq_enable_q <= pwdata[`ADCC_IRQ_DONE];
      if (go) conversion_start_flag_q <= 1'b1; // R3 R8
      else if (sw_stop || finish) conversion_start_flag_q <= 1'b0; // R3 R15
    end
  end

  // Result has no reset: contents survive a system reset
  always @(posedge pclk) begin
    if (finish) result_q <= sar_result; // R9 R11
  end

  // Done request: set beats a clear; a read clears only a bit it returned,
  // so a completion landing between setup and access is not lost
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_done_request_q <= 1'b0;
    end else if (finish) begin
      conversion_done_request_q <= 1'b1; // R4
    end else if ((rd_irq && prdata[`ADCC_IRQ_DONE]) || (wr_irq && !pwdata[`ADCC_IRQ_DONE])) begin
      conversion_done_request_q <= 1'b0;
    end
  end

  // ----------------------------------------
  // Outputs and APB answer
  // ----------------------------------------
  reg [31:0] rdata_d;
  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `ADCC_OFF_MODE: rdata_d[7:0] = {conversion_speed_select_q, ext_trigger_enable_q,
                                      2'b11, channel_select_q};
      `ADCC_OFF_START: rdata_d[7:0] = {conversion_start_flag_q, 7'h7f};
      `ADCC_OFF_RES_HI: rdata_d[7:0] = result_q[BITS-1:BITS-8]; // R17
      `ADCC_OFF_RES_LO: rdata_d[7:0] = {result_q[1:0], 6'h00}; // R17
      `ADCC_OFF_STBY: rdata_d[7:0] = `ADCC_STBY_RST & ~(8'h01 << `ADCC_STBY_ADC) |
                                     ({7'h00, converter_standby_release_q} << `ADCC_STBY_ADC);
      `ADCC_OFF_PORT_MODE_REG1: rdata_d[`ADCC_PORT_MODE_REG1_TRIG] = trigger_pin_function_select_q;
      `ADCC_OFF_EDGE: rdata_d[`ADCC_EDGE_TRIG] = trigger_edge_select_q;
      `ADCC_OFF_IRQ: rdata_d[`ADCC_IRQ_DONE] = conversion_done_request_q;
      `ADCC_OFF_IEN: rdata_d[`ADCC_IRQ_DONE] = conversion_done_irq_enable_q;
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // Zero wait states: pready registered high during the setup cycle
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      irq_q <= 1'b0;
      dac_code_q <= {BITS{1'b0}};
      analog_input_1_sel_q <= 1'b0;
      converter_enable_q <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rdata_d : 32'h0000_0000;
      irq_q <= conversion_done_request_q && conversion_done_irq_enable_q; // R5
      dac_code_q <= sar_code;
      analog_input_1_sel_q <= (channel_select_q == `ADCC_CH_AN1); // R14
      converter_enable_q <= run;
    end
  end

endmodule // adcc_ctrl

`default_nettype wire

// ==== adcc_ctrl_sva.sv ====
/* Checker for the converter control block, seeing only its ports.
   Assumes pclk and the active low asynchronous presetn. */
`timescale 1ns/1ps
`default_nettype none
module adcc_ctrl_sva #(parameter BITS = 10) (
  // APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // Status
  input wire logic low_power,
  input wire logic [3:0] channel_select_q,
  input wire logic analog_input_1_sel_q,
  input wire logic converter_enable_q
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !low_power;
  a_ready_access: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero");
  a_an1_route: assert property (##1 analog_input_1_sel_q == ($past(channel_select_q) == 4'h5))
    else $error("analog input 1 select wrong");
  a_mode_channel: assert property (wr && paddr == 12'h000 |-> ##2 channel_select_q == $past(pwdata[3:0], 2))
    else $error("channel not taken");
  a_lowpwr_off: assert property (low_power ##1 low_power |-> !converter_enable_q)
    else $error("converter runs in low power");
  a_stby_off: assert property (wr && paddr == 12'h010 && !pwdata[4] |-> ##2 !converter_enable_q)
    else $error("standby not entered");
  a_stby_on: assert property (wr && paddr == 12'h010 && pwdata[4] ##1 !low_power[*2] |-> converter_enable_q)
    else $error("standby not released");
endmodule // adcc_ctrl_sva
bind adcc_ctrl adcc_ctrl_sva #(.BITS(BITS)) adcc_ctrl_sva_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .low_power(low_power),
  .channel_select_q(channel_select_q), .analog_input_1_sel_q(analog_input_1_sel_q),
  .converter_enable_q(converter_enable_q));
`default_nettype wire

// ==== adcc_analog_model.sv ====
/* Analog side: comparator on one held input level, and the trigger pin.
   Assumes the trial code is steady before the comparator is read. */
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model #(parameter BITS = 10) (
  // Block side
  input wire logic [BITS-1:0] dac_code_q,
  output logic cmp_hi,
  output logic ext_trigger_pin,
  // Bench side
  input wire logic [BITS-1:0] level,
  input wire logic trig
);
  assign cmp_hi = level >= dac_code_q;
  assign ext_trigger_pin = trig;
endmodule // adcc_analog_model
`default_nettype wire

// ==== adcc_ctrl_tb_top.sv ====
/* Bench for the converter control block over APB.
   Assumes zero-wait APB answers and the analog model beside the block. */
`timescale 1ns/1ps
`default_nettype none
`include "adcc_defs.vh"
module adcc_ctrl_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, low_power, trig;
  logic cmp_hi, pin, an1, en, irq, serr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [3:0] pstrb, chan;
  logic [9:0] lvl, dac;
  int err_total, n_compared;

  adcc_ctrl adcc_ctrl_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .low_power(low_power), .ext_trigger_pin(pin),
    .cmp_hi(cmp_hi), .dac_code_q(dac), .channel_select_q(chan),
    .analog_input_1_sel_q(an1), .converter_enable_q(en), .irq_q(irq));
  adcc_analog_model adcc_analog_model_i (.dac_code_q(dac), .cmp_hi(cmp_hi),
    .ext_trigger_pin(pin), .level(lvl), .trig(trig));

  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    serr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1, a, d);
  endtask
  task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
    apb(0, a, 0);
    check(what, q, exp);
  endtask
  task automatic conv(input logic fast, input logic ien, input logic [9:0] v);
    int n;
    int p;
    p = fast ? `ADCC_FAST_CYCLES : `ADCC_SLOW_CYCLES;
    lvl <= v;
    wr(`ADCC_OFF_IEN, {31'h0, ien});
    wr(`ADCC_OFF_MODE, {24'h0, fast, 7'h35});
    rdc("mode", `ADCC_OFF_MODE, {24'h0, fast, 7'h35});
    check("an1 select", {31'h0, an1}, 1);
    wr(`ADCC_OFF_START, 32'h80);
    rdc("flag set", `ADCC_OFF_START, 32'hff);
    n = 3;
    while (irq !== 1'b1 && n < p + 10) begin
      @(posedge pclk);
      n++;
    end
    if (ien)
      check("done time", {31'h0, n >= p + 1 && n <= p + 4}, 1);
    else
      check("irq masked", {31'h0, irq}, 0);
    rdc("flag clear", `ADCC_OFF_START, 32'h7f);
    rdc("result high", `ADCC_OFF_RES_HI, {24'h0, v[9:2]});
    apb(0, `ADCC_OFF_RES_LO, 0);
    check("result low", {30'h0, q[7:6]}, {30'h0, v[1:0]});
    apb(0, `ADCC_OFF_IRQ, 0);
    check("done request", {31'h0, q[0]}, 1);
    apb(0, `ADCC_OFF_IRQ, 0);
    check("request clear", {31'h0, q[0]}, 0);
    check("irq clear", {31'h0, irq}, 0);
  endtask
  task automatic end_of_test;
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // --------------------
  // Watchdog
  // --------------------
  initial begin
    tick(8000);
    err_total++;
    end_of_test();
  end

  initial begin
    {psel, penable, pwrite, low_power, trig} = 0;
    paddr = 0; pwdata = 0; pstrb = 4'hf; lvl = 0; presetn = 0;
    err_total = 0; n_compared = 0;
    tick(5);
    presetn <= 1;
    rdc("mode reset", `ADCC_OFF_MODE, 32'h30);
    rdc("start reset", `ADCC_OFF_START, 32'h7f);
    rdc("standby reset", `ADCC_OFF_STBY, 32'hff);
    rdc("unmapped", 12'h024, 0);
    check("slverr", {31'h0, serr}, 1);
    pstrb <= 4'he;
    wr(`ADCC_OFF_MODE, 32'h35);
    pstrb <= 4'hf;
    rdc("strobe off", `ADCC_OFF_MODE, 32'h30);
    conv(0, 1, 10'h2a5);
    conv(1, 1, 10'h15a);
    conv(1, 0, 10'h3ff);
    // Stop in mid conversion leaves no done request
    wr(`ADCC_OFF_START, 32'h80);
    tick(10);
    wr(`ADCC_OFF_START, 32'h00);
    rdc("stopped", `ADCC_OFF_START, 32'h7f);
    tick(70);
    apb(0, `ADCC_OFF_IRQ, 0);
    check("no request", {31'h0, q[0]}, 0);
    wr(`ADCC_OFF_STBY, 32'hef);
    tick(2);
    check("standby", {31'h0, en}, 0);
    wr(`ADCC_OFF_START, 32'h80);
    rdc("refused", `ADCC_OFF_START, 32'h7f);
    wr(`ADCC_OFF_STBY, 32'hff);
    tick(10);
    check("released", {31'h0, en}, 1);
    low_power <= 1;
    tick(3);
    check("low power", {31'h0, en}, 0);
    rdc("held", `ADCC_OFF_MODE, 32'hb5);
    low_power <= 0;
    tick(2);
    wr(`ADCC_OFF_EDGE, 32'h10);
    wr(`ADCC_OFF_PORT_MODE_REG1, 32'h0);
    wr(`ADCC_OFF_MODE, 32'h75);
    trig <= 1;
    tick(8);
    rdc("no trigger", `ADCC_OFF_START, 32'h7f);
    trig <= 0;
    tick(8);
    wr(`ADCC_OFF_PORT_MODE_REG1, 32'h10);
    trig <= 1;
    tick(8);
    rdc("trigger start", `ADCC_OFF_START, 32'hff);
    tick(70);
    rdc("trigger done", `ADCC_OFF_START, 32'h7f);
    // Reset after the triggered conversion completes: result survives, mode returns to its reset value
    trig <= 0;
    presetn <= 0;
    tick(2);
    presetn <= 1;
    rdc("result kept", `ADCC_OFF_RES_HI, 32'hff);
    rdc("mode again", `ADCC_OFF_MODE, 32'h30);
    rdc("start again", `ADCC_OFF_START, 32'h7f);
    end_of_test();
  end
endmodule // adcc_ctrl_tb_top
`default_nettype wire
